// ===== inc/chgopt_regs.vh
/*
 Constants for the charger option word zero block: byte addresses,
 field positions, reset values and watchdog timing.
 Assumes a 50 MHz reference clock and an I2C host on the pins.
*/
`ifndef CHGOPT_REGS_VH
`define CHGOPT_REGS_VH

`define CHGOPT_ADDR_OPT_LO      8'h00
`define CHGOPT_ADDR_OPT_HI      8'h01
`define CHGOPT_ADDR_CC_LO       8'h02
`define CHGOPT_ADDR_CC_HI       8'h03
`define CHGOPT_ADDR_CV_LO       8'h04
`define CHGOPT_ADDR_CV_HI       8'h05

`define CHGOPT_OPT_RST          16'hE70E
`define CHGOPT_CC_RST           16'h0000
`define CHGOPT_CV_RST           16'h0000

`define CHGOPT_BIT_LOW_POWER    15
`define CHGOPT_BIT_WD_HI        14
`define CHGOPT_BIT_WD_LO        13
`define CHGOPT_BIT_AUTO_CLEAR   12
`define CHGOPT_BIT_OTG_PG       11
`define CHGOPT_BIT_AUDIBLE      10
`define CHGOPT_BIT_RATE         9
`define CHGOPT_BIT_RIPPLE       8
`define CHGOPT_BIT_LOOP_EN      1

`define CHGOPT_WD_OFF           2'b00
`define CHGOPT_WD_SHORT         2'b01
`define CHGOPT_WD_MID           2'b10
`define CHGOPT_WD_LONG          2'b11

`define CHGOPT_CLK_HZ           36'd50000000
`define CHGOPT_WD_SHORT_S       36'd5
`define CHGOPT_WD_MID_S         36'd88
`define CHGOPT_WD_LONG_S        36'd175
`define CHGOPT_WD_CW            36

`define CHGOPT_I2C_DEV_ADDR     7'h3A

`endif

// ===== hw/chgopt_sync.v
/*
 Two-flop level synchroniser, one lane per bit.
 Assumes inputs are asynchronous to i_ref_clk.
*/
`timescale 1ns/100ps
module chgopt_sync #(
	parameter WIDTH = 6,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
	input  wire             i_ref_clk,
	input  wire             i_rst,
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_lane
			always @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					meta_ff[g] <= RST_VAL[g];
					sync_ff[g] <= RST_VAL[g];
				end else begin
					meta_ff[g] <= i_async[g];
					sync_ff[g] <= meta_ff[g];
				end
			end
		end
	endgenerate
	assign o_sync = sync_ff;
endmodule // chgopt_sync

// ===== hw/chgopt_wdog.v
/*
 Host-write watchdog: counts cycles since the last kick and pulses
 o_expire once when the selected period runs out.
 Assumes periods are given in reference clock cycles.
*/
`timescale 1ns/100ps
`include "chgopt_regs.vh"
module chgopt_wdog #(
	parameter CW = `CHGOPT_WD_CW,
	parameter [CW-1:0] CYC_SHORT = 36'd250000000,
	parameter [CW-1:0] CYC_MID   = 36'd4400000000,
	parameter [CW-1:0] CYC_LONG  = 36'd8750000000
) (
	input  wire       i_ref_clk,
	input  wire       i_rst,
	input  wire [1:0] i_sel,
	input  wire       i_kick,
	output wire       o_expire,
	output wire       o_running
);
	reg [CW-1:0] cnt_ff;
	reg          run_ff;
	reg          expire_ff;
	reg [CW-1:0] limit;

	always @* begin
		case (i_sel)
		`CHGOPT_WD_SHORT: limit = CYC_SHORT;
		`CHGOPT_WD_MID:   limit = CYC_MID;
		default:          limit = CYC_LONG;
		endcase
	end

	// Stays stopped after expiry so a dead host is not retried
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff    <= {CW{1'b0}};
			run_ff    <= 1'b1;
			expire_ff <= 1'b0;
		end else begin
			expire_ff <= 1'b0;
			if (i_kick) begin
				cnt_ff <= {CW{1'b0}};
				run_ff <= 1'b1;
			end else if (i_sel == `CHGOPT_WD_OFF) begin
				cnt_ff <= {CW{1'b0}};
			end else if (run_ff && (cnt_ff >= limit - 1'b1)) begin
				cnt_ff    <= {CW{1'b0}};
				run_ff    <= 1'b0;
				expire_ff <= 1'b1;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	assign o_expire  = expire_ff;
	assign o_running = run_ff;
endmodule // chgopt_wdog

// ===== hw/chgopt_top.v
/*
 Charger option word zero with its I2C slave, plus the charge
 current and charge voltage words that the watchdog watches.
 Assumes SCL/SDA and the analog status levels are asynchronous pins;
 the throttle, monitor and comparator settings come from same-clock logic.
*/
`timescale 1ns/100ps
`include "chgopt_regs.vh"
module chgopt_top #(
	parameter [6:0]  DEV_ADDR  = `CHGOPT_I2C_DEV_ADDR,
	parameter [`CHGOPT_WD_CW-1:0] WD_CYC_SHORT = `CHGOPT_WD_SHORT_S * `CHGOPT_CLK_HZ,
	parameter [`CHGOPT_WD_CW-1:0] WD_CYC_MID   = `CHGOPT_WD_MID_S * `CHGOPT_CLK_HZ,
	parameter [`CHGOPT_WD_CW-1:0] WD_CYC_LONG  = `CHGOPT_WD_LONG_S * `CHGOPT_CLK_HZ
) (
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire        i_scl,
	input  wire        i_sda,
	output wire        o_sda,
	output wire        o_sda_oe,
	input  wire        i_battery_present_n_pin,
	input  wire        i_battery_only,
	input  wire        i_otg_mode,
	input  wire        i_adapter_power_good,
	input  wire        i_throttle_cfg_en,
	input  wire        i_monitor_cfg_en,
	input  wire        i_comparator_cfg_en,
	input  wire        i_lowpower_throttle_profile_enable,
	output reg         o_internal_regulator_output,
	output reg         o_processor_throttle_output,
	output reg         o_monitor_buffers_en,
	output reg         o_comparator_en,
	output reg         o_lowpower_profile_active,
	output reg         o_adc_available,
	output reg         o_power_good_output,
	output reg         o_audible_band_avoid,
	output reg         o_switching_rate_select,
	output reg         o_passthrough_ripple_reduce,
	output reg         o_input_limit_loop_enable,
	output wire [15:0] o_charge_current,
	output wire [15:0] o_charge_voltage,
	output wire        o_watchdog_running
);
	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_ADDR  = 4'h1;
	localparam [3:0] ST_AACK  = 4'h2;
	localparam [3:0] ST_PTR   = 4'h3;
	localparam [3:0] ST_PACK  = 4'h4;
	localparam [3:0] ST_WDATA = 4'h5;
	localparam [3:0] ST_WACK  = 4'h6;
	localparam [3:0] ST_RDATA = 4'h7;
	localparam [3:0] ST_RACK  = 4'h8;

	wire [5:0] pins_sync;
	wire       scl_s;
	wire       sda_s;
	wire       batpres_n_s;
	wire       batt_only_s;
	wire       otg_s;
	wire       adapter_pg_s;
	wire       wd_expire;
	wire       scl_rise;
	wire       scl_fall;
	wire       i2c_start;
	wire       i2c_stop;
	wire       batt_pulled;
	wire       low_power;

	reg [15:0] opt_ff;
	reg [15:0] cc_ff;
	reg [15:0] cv_ff;
	reg        scl_d_ff;
	reg        sda_d_ff;
	reg        batpres_d_ff;
	reg [3:0]  state_ff;
	reg [3:0]  cnt_ff;
	reg [7:0]  shift_ff;
	reg [7:0]  tx_ff;
	reg [7:0]  ptr_ff;
	reg        rw_ff;
	reg        nack_ff;
	reg        sda_oe_ff;
	reg        wr_stb;
	reg        kick;
	reg [7:0]  rd_byte;

	// Pins cross into the clock domain before anything looks at them
	chgopt_sync #(
		.WIDTH   (6),
		.RST_VAL (6'h07)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_async   ({i_adapter_power_good, i_otg_mode, i_battery_only,
		              i_battery_present_n_pin, i_sda, i_scl}),
		.o_sync    (pins_sync)
	);

	assign scl_s        = pins_sync[0];
	assign sda_s        = pins_sync[1];
	assign batpres_n_s  = pins_sync[2];
	assign batt_only_s  = pins_sync[3];
	assign otg_s        = pins_sync[4];
	assign adapter_pg_s = pins_sync[5];

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_d_ff     <= 1'b1;
			sda_d_ff     <= 1'b1;
			batpres_d_ff <= 1'b1;
		end else begin
			scl_d_ff     <= scl_s;
			sda_d_ff     <= sda_s;
			batpres_d_ff <= batpres_n_s;
		end
	end

	assign scl_rise    = scl_s & ~scl_d_ff;
	assign scl_fall    = ~scl_s & scl_d_ff;
	assign i2c_start   = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	assign i2c_stop    = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	assign batt_pulled = batpres_d_ff & ~batpres_n_s;

	// Read mux; unmapped bytes read as zero
	always @* begin
		if (ptr_ff == `CHGOPT_ADDR_OPT_LO) begin
			rd_byte = opt_ff[7:0];
		end else if (ptr_ff == `CHGOPT_ADDR_OPT_HI) begin
			rd_byte = opt_ff[15:8];
		end else if (ptr_ff == `CHGOPT_ADDR_CC_LO) begin
			rd_byte = cc_ff[7:0];
		end else if (ptr_ff == `CHGOPT_ADDR_CC_HI) begin
			rd_byte = cc_ff[15:8];
		end else if (ptr_ff == `CHGOPT_ADDR_CV_LO) begin
			rd_byte = cv_ff[7:0];
		end else if (ptr_ff == `CHGOPT_ADDR_CV_HI) begin
			rd_byte = cv_ff[15:8];
		end else begin
			rd_byte = 8'h00;
		end
	end

	// A data byte lands at the SCL fall that ends its eighth bit
	always @* begin
		wr_stb = (state_ff == ST_WDATA) && scl_fall && (cnt_ff == 4'h8);
		kick   = wr_stb && ((ptr_ff == `CHGOPT_ADDR_CC_LO) ||
		         (ptr_ff == `CHGOPT_ADDR_CC_HI) ||
		         (ptr_ff == `CHGOPT_ADDR_CV_LO) ||
		         (ptr_ff == `CHGOPT_ADDR_CV_HI) ||
		         (ptr_ff == `CHGOPT_ADDR_OPT_HI));
	end

	// I2C slave: sample on SCL rise, change SDA on SCL fall
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_ff  <= ST_IDLE;
			cnt_ff    <= 4'h0;
			shift_ff  <= 8'h00;
			tx_ff     <= 8'h00;
			ptr_ff    <= 8'h00;
			rw_ff     <= 1'b0;
			nack_ff   <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (i2c_stop) begin
			state_ff  <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else if (i2c_start) begin
			state_ff  <= ST_ADDR;
			cnt_ff    <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
			ST_ADDR, ST_PTR, ST_WDATA: begin
				if (scl_rise && (cnt_ff != 4'h8)) begin
					shift_ff <= {shift_ff[6:0], sda_s};
					cnt_ff   <= cnt_ff + 4'h1;
				end else if (scl_fall && (cnt_ff == 4'h8)) begin
					cnt_ff <= 4'h0;
					if (state_ff == ST_ADDR) begin
						if (shift_ff[7:1] == DEV_ADDR) begin
							rw_ff     <= shift_ff[0];
							sda_oe_ff <= 1'b1;
							state_ff  <= ST_AACK;
						end else begin
							state_ff <= ST_IDLE;
						end
					end else if (state_ff == ST_PTR) begin
						ptr_ff    <= shift_ff;
						sda_oe_ff <= 1'b1;
						state_ff  <= ST_PACK;
					end else begin
						ptr_ff    <= ptr_ff + 8'h01;
						sda_oe_ff <= 1'b1;
						state_ff  <= ST_WACK;
					end
				end
			end
			ST_AACK: begin
				if (scl_fall && rw_ff) begin
					tx_ff     <= rd_byte;
					sda_oe_ff <= ~rd_byte[7];
					cnt_ff    <= 4'h1;
					state_ff  <= ST_RDATA;
				end else if (scl_fall) begin
					sda_oe_ff <= 1'b0;
					state_ff  <= ST_PTR;
				end
			end
			ST_PACK, ST_WACK: begin
				if (scl_fall) begin
					sda_oe_ff <= 1'b0;
					state_ff  <= ST_WDATA;
				end
			end
			ST_RDATA: begin
				if (scl_fall && (cnt_ff == 4'h8)) begin
					sda_oe_ff <= 1'b0;
					ptr_ff    <= ptr_ff + 8'h01;
					state_ff  <= ST_RACK;
				end else if (scl_fall) begin
					sda_oe_ff <= ~tx_ff[3'd7 - cnt_ff[2:0]];
					cnt_ff    <= cnt_ff + 4'h1;
				end
			end
			ST_RACK: begin
				if (scl_rise) begin
					nack_ff <= sda_s;
				end else if (scl_fall && nack_ff) begin
					state_ff <= ST_IDLE;
				end else if (scl_fall) begin
					tx_ff     <= rd_byte;
					sda_oe_ff <= ~rd_byte[7];
					cnt_ff    <= 4'h1;
					state_ff  <= ST_RDATA;
				end
			end
			default: begin
				sda_oe_ff <= 1'b0;
			end
			endcase
		end
	end

	// Open drain: only ever pulls low
	assign o_sda    = 1'b0;
	assign o_sda_oe = sda_oe_ff;

	// Option word; battery pull clears loop enable over a same-cycle write
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			opt_ff <= `CHGOPT_OPT_RST;
		end else begin
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_OPT_LO)) begin
				opt_ff[7:0] <= shift_ff;
			end
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_OPT_HI)) begin
				opt_ff[15:8] <= shift_ff;
			end
			if (batt_pulled && opt_ff[`CHGOPT_BIT_AUTO_CLEAR]) begin
				opt_ff[`CHGOPT_BIT_LOOP_EN] <= 1'b0;
			end
		end
	end

	// Charge current; expiry beats a same-cycle host byte
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cc_ff <= `CHGOPT_CC_RST;
			cv_ff <= `CHGOPT_CV_RST;
		end else begin
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_CC_LO)) begin
				cc_ff[7:0] <= shift_ff;
			end
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_CC_HI)) begin
				cc_ff[15:8] <= shift_ff;
			end
			if (wd_expire) begin
				cc_ff <= 16'h0000;
			end
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_CV_LO)) begin
				cv_ff[7:0] <= shift_ff;
			end
			if (wr_stb && (ptr_ff == `CHGOPT_ADDR_CV_HI)) begin
				cv_ff[15:8] <= shift_ff;
			end
		end
	end

	chgopt_wdog #(
		.CW        (`CHGOPT_WD_CW),
		.CYC_SHORT (WD_CYC_SHORT),
		.CYC_MID   (WD_CYC_MID),
		.CYC_LONG  (WD_CYC_LONG)
	) u_wdog (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_sel     (opt_ff[`CHGOPT_BIT_WD_HI:`CHGOPT_BIT_WD_LO]),
		.i_kick    (kick),
		.o_expire  (wd_expire),
		.o_running (o_watchdog_running)
	);

	assign o_charge_current = cc_ff;
	assign o_charge_voltage = cv_ff;

	// Low power only bites on battery alone; adapter use is the host's care
	assign low_power = opt_ff[`CHGOPT_BIT_LOW_POWER] & batt_only_s;

	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_internal_regulator_output <= 1'b1;
			o_processor_throttle_output <= 1'b0;
			o_monitor_buffers_en        <= 1'b0;
			o_comparator_en             <= 1'b0;
			o_lowpower_profile_active   <= 1'b0;
			o_adc_available             <= 1'b1;
			o_power_good_output         <= 1'b0;
			o_audible_band_avoid        <= 1'b1;
			o_switching_rate_select     <= 1'b1;
			o_passthrough_ripple_reduce <= 1'b1;
			o_input_limit_loop_enable   <= 1'b1;
		end else begin
			o_internal_regulator_output <= ~low_power;
			o_adc_available             <= ~low_power;
			o_processor_throttle_output <= ~low_power & i_throttle_cfg_en;
			o_monitor_buffers_en        <= ~low_power & i_monitor_cfg_en;
			if (low_power) begin
				o_comparator_en <= i_lowpower_throttle_profile_enable;
			end else begin
				o_comparator_en <= i_comparator_cfg_en;
			end
			o_lowpower_profile_active <= low_power & i_lowpower_throttle_profile_enable;
			o_power_good_output <= adapter_pg_s |
				(opt_ff[`CHGOPT_BIT_OTG_PG] & otg_s);
			o_audible_band_avoid        <= opt_ff[`CHGOPT_BIT_AUDIBLE];
			o_switching_rate_select     <= opt_ff[`CHGOPT_BIT_RATE];
			o_passthrough_ripple_reduce <= opt_ff[`CHGOPT_BIT_RIPPLE];
			o_input_limit_loop_enable   <= opt_ff[`CHGOPT_BIT_LOOP_EN];
		end
	end
endmodule // chgopt_top

// ===== test/chgopt_host.sv
/*
 I2C controller model that talks to the option word block.
 Assumes the bench resolves SDA as a pulled-up open-drain wire.
*/
`timescale 1ns/100ps
module chgopt_host #(
	parameter [6:0] DEV = 7'h00
) (
	input  wire i_ref_clk,
	input  wire i_sda,
	output reg  o_scl,
	output reg  o_sda_oe
);
	// Five cycles a phase; the device needs at least four
	localparam HALF = 5;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	task tick(input integer n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	// Data moves one cycle after SCL falls, never with it
	task bits9(input [8:0] d, output [8:0] q);
		integer k;
		for (k = 8; k >= 0; k = k - 1) begin
			tick(1);
			o_sda_oe = ~d[k];
			tick(HALF);
			o_scl = 1'b1;
			tick(HALF);
			q[k] = i_sda;
			o_scl = 1'b0;
		end
	endtask
	task strt;
		tick(1);
		o_sda_oe = 1'b0;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda_oe = 1'b1;
		tick(HALF);
		o_scl = 1'b0;
	endtask
	task stop;
		tick(1);
		o_sda_oe = 1'b1;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda_oe = 1'b0;
		tick(HALF);
	endtask
	// Host writes one byte to pointer a; ok only if all three bytes were acked
	task wr(input [7:0] a, input [7:0] d, output ok);
		reg [8:0] q1, q2, q3;
		strt;
		bits9({DEV, 1'b0, 1'b1}, q1);
		bits9({a, 1'b1}, q2);
		bits9({d, 1'b1}, q3);
		stop;
		ok = ~(q1[0] | q2[0] | q3[0]);
	endtask
	task rd(input [7:0] a, output [7:0] v);
		reg [8:0] q1;
		strt;
		bits9({DEV, 1'b0, 1'b1}, q1);
		bits9({a, 1'b1}, q1);
		strt;
		bits9({DEV, 1'b1, 1'b1}, q1);
		bits9(9'h1FF, q1);
		stop;
		v = q1[8:1];
	endtask
endmodule // chgopt_host

// ===== test/chgopt_top_chk.sv
/*
 Assertions on the option word block ports.
 Assumes one clock and an active high asynchronous reset.
*/
`timescale 1ns/100ps
module chgopt_chk #(
	parameter [35:0] WD_CYC_SHORT = 36'd200
) (
	input wire        i_ref_clk,
	input wire        i_rst,
	input wire        i_scl,
	input wire        i_adapter_power_good,
	input wire        i_otg_mode,
	input wire        i_throttle_cfg_en,
	input wire        i_monitor_cfg_en,
	input wire        i_comparator_cfg_en,
	input wire        i_lowpower_throttle_profile_enable,
	input wire        o_sda,
	input wire        o_sda_oe,
	input wire        o_internal_regulator_output,
	input wire        o_processor_throttle_output,
	input wire        o_monitor_buffers_en,
	input wire        o_comparator_en,
	input wire        o_adc_available,
	input wire        o_power_good_output,
	input wire        o_audible_band_avoid,
	input wire        o_switching_rate_select,
	input wire        o_passthrough_ripple_reduce,
	input wire        o_input_limit_loop_enable,
	input wire [15:0] o_charge_current,
	input wire        o_watchdog_running
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Only a lower bound: kicks are not visible here
	reg [35:0] run_cnt_ff;
	always @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			run_cnt_ff <= 36'h0;
		else if (!o_watchdog_running)
			run_cnt_ff <= 36'h0;
		else
			run_cnt_ff <= run_cnt_ff + 36'h1;
	end
	a_reset_copies: assert property (
		$fell(i_rst) |-> o_audible_band_avoid && o_switching_rate_select
		&& o_passthrough_ripple_reduce && o_input_limit_loop_enable) else $error("reset copies");
	a_expire_zero: assert property (
		$fell(o_watchdog_running) |-> ##[0:1] o_charge_current == 16'h0000)
		else $error("current not zeroed");
	a_wd_min: assert property (
		$fell(o_watchdog_running) |-> run_cnt_ff + 36'h4 >= WD_CYC_SHORT)
		else $error("watchdog early");
	a_lp_group: assert property (
		!o_internal_regulator_output |-> !o_adc_available && !o_processor_throttle_output
		&& !o_monitor_buffers_en) else $error("low power group");
	a_lp_profile: assert property (
		!o_internal_regulator_output && !$past(i_rst)
		|-> o_comparator_en == $past(i_lowpower_throttle_profile_enable))
		else $error("profile comparator");
	a_perf_cfg: assert property (
		o_internal_regulator_output && !$past(i_rst)
		|-> o_comparator_en == $past(i_comparator_cfg_en)
		&& o_processor_throttle_output == $past(i_throttle_cfg_en)
		&& o_monitor_buffers_en == $past(i_monitor_cfg_en)) else $error("cfg follow");
	a_adc_on: assert property (
		o_internal_regulator_output |-> o_adc_available) else $error("adc off");
	a_pg_cause: assert property (
		$rose(o_power_good_output) |-> $past(i_adapter_power_good, 3) || $past(i_otg_mode, 3))
		else $error("power good cause");
	a_sda_open: assert property (
		o_sda == 1'b0) else $error("sda driven high");
	// Device moves SDA only while the clock pin is low
	a_sda_scl_low: assert property (
		$changed(o_sda_oe) |-> !i_scl) else $error("sda moved with scl high");
	c_expire: cover property ($fell(o_watchdog_running));
	c_lowpower: cover property ($fell(o_internal_regulator_output));
	c_pg: cover property ($rose(o_power_good_output));
	c_loop_clr: cover property ($fell(o_input_limit_loop_enable));
endmodule // chgopt_chk
bind chgopt_top chgopt_chk #(
	.WD_CYC_SHORT(WD_CYC_SHORT)
) u_chk (
	.i_ref_clk, .i_rst, .i_scl, .i_adapter_power_good, .i_otg_mode, .i_throttle_cfg_en,
	.i_monitor_cfg_en, .i_comparator_cfg_en, .i_lowpower_throttle_profile_enable, .o_sda,
	.o_internal_regulator_output, .o_processor_throttle_output, .o_monitor_buffers_en,
	.o_comparator_en, .o_adc_available, .o_power_good_output, .o_audible_band_avoid,
	.o_switching_rate_select, .o_passthrough_ripple_reduce, .o_input_limit_loop_enable,
	.o_charge_current, .o_watchdog_running, .o_sda_oe
);

// ===== test/tb_charger_option_word_zero.sv
/*
 Bench for the option word block with an I2C host model.
 Assumes design, header and checker are compiled alongside.
*/
`timescale 1ns/100ps
`include "chgopt_regs.vh"
module tb_charger_option_word_zero;
	// Short periods keep the run brief
	localparam integer P1 = 2000, P2 = 4000, P3 = 8000;
	reg         i_ref_clk = 1'b0, i_rst = 1'b1;
	reg         bp_n = 1'b1, bat_only = 1'b0, otg = 1'b0, apg = 1'b0, ok;
	reg  [3:0]  cfg = 4'h0;
	reg  [15:0] m_word, m_cc, m_cv;
	reg  [31:0] rs = 32'd45662;
	reg  [7:0]  q;
	wire        sda_oe, h_oe, scl, sda, o_sda, reg_on, thr, mon, cmp, adc, pg;
	wire        aud, rate, rip, loop, run, lp_act;
	wire [15:0] cc, cv;
	integer     n_errors = 0, checks = 0, cyc = 0, i, t, pe;
	assign sda = ~(h_oe | (sda_oe & ~o_sda));
	always #10 i_ref_clk = ~i_ref_clk;
	chgopt_top #(.WD_CYC_SHORT(36'(P1)), .WD_CYC_MID(36'(P2)), .WD_CYC_LONG(36'(P3))) dut (
		.i_ref_clk, .i_rst, .i_scl(scl), .i_sda(sda), .o_sda, .o_sda_oe(sda_oe),
		.i_battery_present_n_pin(bp_n), .i_battery_only(bat_only), .i_otg_mode(otg),
		.i_adapter_power_good(apg), .i_throttle_cfg_en(cfg[0]), .i_monitor_cfg_en(cfg[1]),
		.i_comparator_cfg_en(cfg[2]), .i_lowpower_throttle_profile_enable(cfg[3]),
		.o_internal_regulator_output(reg_on), .o_processor_throttle_output(thr),
		.o_monitor_buffers_en(mon), .o_comparator_en(cmp), .o_lowpower_profile_active(lp_act),
		.o_adc_available(adc), .o_power_good_output(pg), .o_audible_band_avoid(aud),
		.o_switching_rate_select(rate), .o_passthrough_ripple_reduce(rip),
		.o_input_limit_loop_enable(loop), .o_charge_current(cc), .o_charge_voltage(cv),
		.o_watchdog_running(run));
	chgopt_host #(.DEV(`CHGOPT_I2C_DEV_ADDR)) host (
		.i_ref_clk, .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
	function [31:0] xs(input [31:0] s);
		reg [31:0] v;
		begin
			v = s ^ (s << 13);
			v = v ^ (v >> 17);
			xs = v ^ (v << 5);
		end
	endfunction
	task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
		checks = checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("wrong value %0s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		host.wr(a, d, ok);
		chk("ack", 16'h1, {15'h0, ok});
		if (a == 8'h00) m_word[7:0] = d;
		if (a == 8'h01) m_word[15:8] = d;
		if (a == 8'h02) m_cc[7:0] = d;
		if (a == 8'h03) m_cc[15:8] = d;
		if (a == 8'h04) m_cv[7:0] = d;
		if (a == 8'h05) m_cv[15:8] = d;
		repeat (3) @(negedge i_ref_clk);
	endtask
	task rdw;
		host.rd(8'h00, q);
		chk("word_lo", {8'h0, m_word[7:0]}, {8'h0, q});
		host.rd(8'h01, q);
		chk("word_hi", {8'h0, m_word[15:8]}, {8'h0, q});
		chk("copies", {12'h0, m_word[10:8], m_word[1]}, {12'h0, aud, rate, rip, loop});
	endtask
	task summarize;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge i_ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 70000) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	initial begin
		for (t = 0; t < 2; t = t + 1) begin
			m_word = `CHGOPT_OPT_RST;
			m_cc = 16'h0;
			m_cv = 16'h0;
			i_rst = 1'b1;
			repeat (12) @(negedge i_ref_clk);
			i_rst = 1'b0;
			repeat (4) @(negedge i_ref_clk);
			rdw;
		end
		host.rd(8'h06, q);
		chk("unmapped", 16'h0, {8'h0, q});
		for (i = 0; i < 4; i = i + 1) begin
			rs = xs(rs);
			wr(8'h00, rs[7:0]);
			wr(8'h01, {rs[15], 2'b11, rs[12:8]});
			rdw;
		end
		for (i = 1; i < 4; i = i + 1) begin
			pe = (i == 1) ? P1 : (i == 2) ? P2 : P3;
			wr(8'h01, {1'b0, i[1:0], 5'h07});
			wr(8'h03, 8'h12);
			for (t = 0; run === 1'b1 && t < 9000; t = t + 1)
				@(negedge i_ref_clk);
			chk("wd_time", 16'h1, {15'h0, t > pe - 45 && t < pe - 10});
			// Zeroing lands one cycle after the running flag drops
			@(negedge i_ref_clk);
			m_cc = 16'h0;
			chk("cc_zero", m_cc, cc);
			wr(8'h02, 8'h40);
			chk("cc_new", m_cc, cc);
			chk("restart", 16'h1, {15'h0, run});
		end
		wr(8'h01, 8'h07);
		repeat (P3 + 100) @(negedge i_ref_clk);
		chk("wd_off", 16'h1, {15'h0, run});
		wr(8'h01, 8'h27);
		for (i = 0; i < 4; i = i + 1) begin
			wr(i[0] ? 8'h05 : 8'h03, 8'h05);
			repeat (P1 / 2) @(negedge i_ref_clk);
		end
		chk("kept_alive", 16'h1, {15'h0, run});
		chk("cv", m_cv, cv);
		// Auto clear on, then off
		for (i = 0; i < 2; i = i + 1) begin
			wr(8'h01, {3'h0, ~i[0], 4'h7});
			wr(8'h00, 8'h0E);
			bp_n = 1'b0;
			if (!i[0]) m_word[1] = 1'b0;
			repeat (6) @(negedge i_ref_clk);
			chk("auto_clear", {15'h0, m_word[1]}, {15'h0, loop});
			bp_n = 1'b1;
			rdw;
		end
		bat_only = 1'b1; // no adapter while low power is used
		for (i = 0; i < 6; i = i + 1) begin
			rs = xs(rs);
			cfg = rs[3:0];
			wr(8'h01, {i[0], 7'h07});
			repeat (4) @(negedge i_ref_clk);
			chk("lowpower", i[0] ? {10'h0, 4'h0, cfg[3], cfg[3]}
				: {10'h0, 2'b11, cfg[0], cfg[1], cfg[2], 1'b0},
				{10'h0, reg_on, adc, thr, mon, cmp, lp_act});
		end
		bat_only = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			apg = i[1];
			otg = i[2];
			wr(8'h01, {4'h0, i[0], 3'h7});
			chk("pg", {15'h0, i[1] | (i[0] & i[2])}, {15'h0, pg});
		end
		summarize;
	end
endmodule // tb_charger_option_word_zero
